// ===== bts_defines.svh
// constants for the best-three-of-eighteen sorter block
// assumes register indices are word indices: byte address = 4 * index
`ifndef BTS_DEFINES_SVH
`define BTS_DEFINES_SVH
`define BTS_CLK_PERIOD_NS 10
`define BTS_STRETCH_US    10000
`define BTS_NCAND         6
`define BTS_NSORT         18
`define BTS_NRANK         3
`define BTS_QW            8
`define BTS_LUT_AW        10
`define BTS_LUTA_W        13
`define BTS_CW            40
`define BTS_OUT_W         120
`define BTS_DEPTH         8
`define BTS_PW            4
`define BTS_CNT_W         3
`define BTS_LAST          3'h7
`define BTS_PIPE          4
`define BTS_WIN_W         5
`define BTS_LANE_W        16
`define BTS_LANE_IW       4
`define BTS_NSRC_LANE     15
`define BTS_NRES_LANE     9
`define BTS_RES_W         144
`define BTS_IDX_RES0      8'h00
`define BTS_IDX_RES_END   8'h10
`define BTS_IDX_SRC0      8'h20
`define BTS_IDX_SRC_END   8'h3c
`define BTS_IDX_CTRL1     8'h40
`define BTS_IDX_FRAME     8'h44
`define BTS_IDX_SERRST    8'h46
`define BTS_IDX_BUFRST    8'h48
`define BTS_IDX_LOGRST    8'h4a
`define BTS_IDX_CTRL2     8'h50
`define BTS_IDX_LUTA      8'h60
`define BTS_IDX_LUTD      8'h62
`define BTS_CTRL1_W       2
`define BTS_CTRL2_W       10
`define BTS_CTRL1_RST     2'h0
`define BTS_CTRL2_RST     10'h000
`define BTS_TEST_BIT      0
`define BTS_ARM_BIT       9
`define BTS_SEL_LSB       10
`endif

// ===== bts_pkg.sv
// types shared by the sorter block
// assumes nothing beyond the defines header
package bts_pkg;
  typedef struct packed {
    logic [19:0] word_hi;
    logic [1:0]  wire_quality_bits;
    logic [8:0]  misc;
    logic [7:0]  strip_pattern_bits;
    logic        flag;
  } bts_cand_s;
  typedef enum logic [0:0] {BTS_IDLE = 1'b0, BTS_SEND = 1'b1} bts_send_e;
  typedef logic [7:0] bts_qual_t;
endpackage

// ===== bts_oneshot.sv
// retriggerable pulse stretcher for front-panel indicators
// assumes trig is synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module bts_oneshot #(
  parameter int unsigned LEN = 1000000,
  parameter int unsigned CW  = 21
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig,
  output logic      lit
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    if (trig) begin
      cnt_next = CW'(LEN);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      lit     <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      lit     <= (cnt_next != '0);
    end
  end
endmodule
`default_nettype wire

// ===== bts_top.sv
// best three of eighteen candidate sorter with test buffers, apb slave
// assumes trig_cand is on pclk; bunch_zero_strobe arrives from another board
`timescale 1ns/1ps
`default_nettype none
`include "bts_defines.svh"
module bts_top #(
  parameter int unsigned STRETCH_CYC = (`BTS_STRETCH_US * 1000) / `BTS_CLK_PERIOD_NS
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [9:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire bts_pkg::bts_cand_s [`BTS_NCAND-1:0] trig_cand,
  input  wire logic                          bunch_zero_strobe,
  output logic      [`BTS_OUT_W-1:0]         ser_data,
  output logic                               ser_reset,
  output logic                               ser_frame,
  output logic      [`BTS_NCAND-1:0]         cand_ind,
  output logic      [`BTS_NRANK-1:0]         ranked_output_indicators,
  output logic                               test_ind,
  output logic                               access_ind
);
  localparam int unsigned OSW = 21;

  logic [7:0] idx;
  logic setup, access, wr_done, rd_done, mapped;
  logic d_ctrl1, d_ctrl2, d_frame, d_serrst, d_bufrst, d_logrst, d_luta, d_lutd, d_src, d_res;
  logic [`BTS_LANE_IW-1:0] lane;
  logic [`BTS_CTRL1_W-1:0] ctrl1_reg, ctrl1_next;
  logic [`BTS_CTRL2_W-1:0] ctrl2_reg, ctrl2_next;
  logic [`BTS_LUTA_W-1:0]  luta_reg, luta_next;
  bts_pkg::bts_send_e      send_reg, send_next;
  logic [`BTS_CNT_W-1:0]   cnt_reg, cnt_next;
  logic [`BTS_PW-1:0]      src_wp_reg [`BTS_NSRC_LANE];
  logic [`BTS_PW-1:0]      src_wp_next [`BTS_NSRC_LANE];
  logic [`BTS_PW-1:0]      res_rp_reg [`BTS_NRES_LANE];
  logic [`BTS_PW-1:0]      res_rp_next [`BTS_NRES_LANE];
  logic [`BTS_PW-1:0]      res_wp_reg, res_wp_next;
  logic [31:0]             prdata_reg, prdata_next;
  logic                    err_reg, err_next, cap;
  logic                    b0_s1, b0_s2, b0_s3, b0_lvl_reg, b0_rise;
  logic [`BTS_CW*`BTS_NCAND-1:0] src_mem [`BTS_DEPTH];
  logic [`BTS_RES_W-1:0]         res_mem [`BTS_DEPTH];
  bts_pkg::bts_cand_s [`BTS_NCAND-1:0] c0_reg, c0_next, c1_reg, c2_reg, c3_reg;
  bts_pkg::bts_cand_s [`BTS_NRANK-1:0] out_reg, out_next;
  bts_pkg::bts_qual_t      q_reg [`BTS_NCAND];
  bts_pkg::bts_qual_t      qs [`BTS_NSORT];
  logic [`BTS_NSORT-1:0]   beat_reg [`BTS_NSORT];
  logic [`BTS_NSORT-1:0]   beat_next [`BTS_NSORT];
  logic [`BTS_WIN_W-1:0]   wins [`BTS_NSORT];
  logic [`BTS_NSORT-1:0]   sel_reg [`BTS_NRANK];
  logic [`BTS_NSORT-1:0]   sel_next [`BTS_NRANK];
  logic [`BTS_PIPE:0]      vld_reg, vld_next;

  // zero-wait slave: read data is prepared in the setup cycle
  assign idx     = paddr[9:2];
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = access;
  assign wr_done = access & pwrite;
  assign rd_done = access & ~pwrite;
  assign prdata  = prdata_reg;
  assign pslverr = access & err_reg;
  assign test_ind = ctrl1_reg[`BTS_TEST_BIT];
  assign ser_data = out_reg;

  always_comb begin
    {d_ctrl1, d_ctrl2, d_frame, d_serrst, d_bufrst, d_logrst, d_luta, d_lutd} = '0;
    d_src = 1'b0;
    d_res = 1'b0;
    lane  = '0;
    if (idx == `BTS_IDX_CTRL1) begin
      d_ctrl1 = 1'b1;
    end else if (idx == `BTS_IDX_CTRL2) begin
      d_ctrl2 = 1'b1;
    end else if (idx == `BTS_IDX_FRAME) begin
      d_frame = 1'b1;
    end else if (idx == `BTS_IDX_SERRST) begin
      d_serrst = 1'b1;
    end else if (idx == `BTS_IDX_BUFRST) begin
      d_bufrst = 1'b1;
    end else if (idx == `BTS_IDX_LOGRST) begin
      d_logrst = 1'b1;
    end else if (idx == `BTS_IDX_LUTA) begin
      d_luta = 1'b1;
    end else if (idx == `BTS_IDX_LUTD) begin
      d_lutd = 1'b1;
    end else if (idx <= `BTS_IDX_RES_END && !idx[0]) begin
      d_res = 1'b1;
      lane  = `BTS_LANE_IW'((idx - `BTS_IDX_RES0) >> 1);
    end else if (idx >= `BTS_IDX_SRC0 && idx <= `BTS_IDX_SRC_END && !idx[0]) begin
      d_src = 1'b1;
      lane  = `BTS_LANE_IW'((idx - `BTS_IDX_SRC0) >> 1);
    end
    mapped = d_ctrl1 | d_ctrl2 | d_frame | d_serrst | d_bufrst | d_logrst |
             d_luta | d_lutd | d_src | d_res;
  end

  // control, send sequencing and buffer pointers
  always_comb begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    luta_next  = luta_reg;
    send_next  = send_reg;
    cnt_next   = cnt_reg;
    if (wr_done && d_ctrl1) ctrl1_next = pwdata[`BTS_CTRL1_W-1:0];
    if (wr_done && d_ctrl2) ctrl2_next = pwdata[`BTS_CTRL2_W-1:0];
    if (wr_done && d_luta) luta_next = pwdata[`BTS_LUTA_W-1:0];
    if (wr_done && d_lutd) luta_next = luta_reg + 1'b1;
    case (send_reg)
      bts_pkg::BTS_IDLE: begin
        if (b0_rise && ctrl2_reg[`BTS_ARM_BIT]) begin
          send_next = bts_pkg::BTS_SEND;
          cnt_next  = '0;
        end
      end
      bts_pkg::BTS_SEND: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == `BTS_LAST) send_next = bts_pkg::BTS_IDLE;
      end
      default: send_next = bts_pkg::BTS_IDLE;
    endcase
    if (wr_done && d_logrst) begin
      ctrl1_next = `BTS_CTRL1_RST;
      ctrl2_next = `BTS_CTRL2_RST;
      send_next  = bts_pkg::BTS_IDLE;
      cnt_next   = '0;
    end
    cap = vld_reg[`BTS_PIPE] && res_wp_reg != `BTS_PW'(`BTS_DEPTH);
    res_wp_next = cap ? res_wp_reg + 1'b1 : res_wp_reg;
    for (int l = 0; l < `BTS_NSRC_LANE; l++) begin
      src_wp_next[l] = src_wp_reg[l];
      if (wr_done && d_src && lane == `BTS_LANE_IW'(l) &&
          src_wp_reg[l] != `BTS_PW'(`BTS_DEPTH)) src_wp_next[l] = src_wp_reg[l] + 1'b1;
      if (wr_done && d_bufrst) src_wp_next[l] = '0;
    end
    for (int l = 0; l < `BTS_NRES_LANE; l++) begin
      res_rp_next[l] = res_rp_reg[l];
      if (rd_done && d_res && lane == `BTS_LANE_IW'(l) &&
          res_rp_reg[l] != res_wp_reg) res_rp_next[l] = res_rp_reg[l] + 1'b1;
      if (wr_done && d_bufrst) res_rp_next[l] = '0;
    end
    if (wr_done && d_bufrst) res_wp_next = '0;
  end

  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (setup) begin
      prdata_next = '0;
      err_next    = ~mapped;
      if (!pwrite) begin
        if (d_ctrl1) begin
          prdata_next = 32'(ctrl1_reg);
        end else if (d_ctrl2) begin
          prdata_next = 32'(ctrl2_reg);
        end else if (d_luta) begin
          prdata_next = 32'(luta_reg);
        end else if (d_res && res_rp_reg[lane] != res_wp_reg) begin
          prdata_next = 32'(res_mem[res_rp_reg[lane][`BTS_CNT_W-1:0]]
                            [int'(lane) * `BTS_LANE_W +: `BTS_LANE_W]);
        end
      end
    end
  end

  // datapath: source select, sorter compare, ranking, output mux
  always_comb begin
    if (ctrl1_reg[`BTS_TEST_BIT]) begin
      c0_next = (send_reg == bts_pkg::BTS_SEND) ? src_mem[cnt_reg] : '0;
    end else begin
      c0_next = trig_cand;
    end
    vld_next = {vld_reg[`BTS_PIPE-1:0], send_reg == bts_pkg::BTS_SEND};
    for (int i = 0; i < `BTS_NSORT; i++) qs[i] = '0;
    for (int i = 0; i < `BTS_NCAND; i++) qs[i] = q_reg[i];
    for (int i = 0; i < `BTS_NSORT; i++) begin
      for (int j = 0; j < `BTS_NSORT; j++) begin
        // bit j set: input j outranks input i
        beat_next[i][j] = (qs[j] > qs[i]) || (qs[j] == qs[i] && j < i);
      end
    end
    for (int i = 0; i < `BTS_NSORT; i++) begin
      wins[i] = '0;
      for (int j = 0; j < `BTS_NSORT; j++) begin
        wins[i] = wins[i] + `BTS_WIN_W'(beat_reg[i][j]);
      end
    end
    for (int k = 0; k < `BTS_NRANK; k++) begin
      for (int i = 0; i < `BTS_NSORT; i++) begin
        sel_next[k][i] = (wins[i] == `BTS_WIN_W'(k));
      end
    end
    for (int k = 0; k < `BTS_NRANK; k++) begin
      out_next[k] = '0;
      // zero-forced inputs carry empty candidates
      for (int i = 0; i < `BTS_NCAND; i++) begin
        if (sel_reg[k][i]) out_next[k] = c3_reg[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg  <= `BTS_CTRL1_RST;
      ctrl2_reg  <= `BTS_CTRL2_RST;
      luta_reg   <= '0;
      send_reg   <= bts_pkg::BTS_IDLE;
      cnt_reg    <= '0;
      res_wp_reg <= '0;
      prdata_reg <= '0;
      err_reg    <= 1'b0;
      ser_reset  <= 1'b0;
      ser_frame  <= 1'b0;
      {b0_s1, b0_s2, b0_s3, b0_lvl_reg} <= '0;
      for (int l = 0; l < `BTS_NSRC_LANE; l++) src_wp_reg[l] <= '0;
      for (int l = 0; l < `BTS_NRES_LANE; l++) res_rp_reg[l] <= '0;
      {c0_reg, c1_reg, c2_reg, c3_reg, out_reg} <= '0;
      vld_reg <= '0;
      for (int i = 0; i < `BTS_NSORT; i++) beat_reg[i] <= '0;
      for (int k = 0; k < `BTS_NRANK; k++) sel_reg[k] <= '0;
    end else begin
      ctrl1_reg  <= ctrl1_next;
      ctrl2_reg  <= ctrl2_next;
      luta_reg   <= luta_next;
      send_reg   <= send_next;
      cnt_reg    <= cnt_next;
      res_wp_reg <= res_wp_next;
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
      ser_reset  <= wr_done & d_serrst;
      ser_frame  <= wr_done & d_frame;
      b0_s1      <= bunch_zero_strobe;
      b0_s2      <= b0_s1;
      b0_s3      <= b0_s2;
      if (b0_s2 == b0_s3) b0_lvl_reg <= b0_s3;
      src_wp_reg <= src_wp_next;
      res_rp_reg <= res_rp_next;
      c0_reg     <= c0_next;
      c1_reg     <= c0_reg;
      c2_reg     <= c1_reg;
      c3_reg     <= c2_reg;
      out_reg    <= out_next;
      vld_reg    <= vld_next;
      beat_reg   <= beat_next;
      sel_reg    <= sel_next;
    end
  end

  // counts once the two later stages agree
  assign b0_rise = (b0_s2 == b0_s3) && b0_s3 && !b0_lvl_reg;

  always_ff @(posedge pclk) begin
    if (wr_done && d_src && src_wp_reg[lane] != `BTS_PW'(`BTS_DEPTH)) begin
      src_mem[src_wp_reg[lane][`BTS_CNT_W-1:0]][int'(lane) * `BTS_LANE_W +: `BTS_LANE_W]
        <= pwdata[`BTS_LANE_W-1:0];
    end
    if (cap) res_mem[res_wp_reg[`BTS_CNT_W-1:0]] <= `BTS_RES_W'(out_reg);
  end

  for (genvar k = 0; k < `BTS_NCAND; k++) begin : g_lut
    logic [`BTS_QW-1:0] quality_lookup_memory [1 << `BTS_LUT_AW];
    always_ff @(posedge pclk) begin
      if (wr_done && d_lutd && luta_reg[`BTS_LUTA_W-1:`BTS_LUT_AW] == 3'(k)) begin
        quality_lookup_memory[luta_reg[`BTS_LUT_AW-1:0]] <= pwdata[`BTS_QW-1:0];
      end
      q_reg[k] <= quality_lookup_memory[{c0_reg[k].wire_quality_bits,
                                          c0_reg[k].strip_pattern_bits}];
    end
    bts_oneshot #(.LEN(STRETCH_CYC), .CW(OSW)) u_cand_os (
      .pclk(pclk), .presetn(presetn), .trig(c1_reg[k].flag), .lit(cand_ind[k]));
  end

  for (genvar k = 0; k < `BTS_NRANK; k++) begin : g_rank_os
    bts_oneshot #(.LEN(STRETCH_CYC), .CW(OSW)) u_rank_os (
      .pclk(pclk), .presetn(presetn), .trig(out_reg[k].flag),
      .lit(ranked_output_indicators[k]));
  end

  bts_oneshot #(.LEN(STRETCH_CYC), .CW(OSW)) u_access_os (
    .pclk(pclk), .presetn(presetn), .trig(access), .lit(access_ind));
endmodule
`default_nettype wire

// ===== bts_top_assertions.sv
// concurrent checks bound onto the sorter top
// assumes zero-wait apb and registered indicator outputs
`timescale 1ns/1ps
`default_nettype none
`include "bts_defines.svh"
module bts_top_assertions #(
  parameter int unsigned STRETCH_CYC = 5
) (
  input wire logic                               pclk,
  input wire logic                               presetn,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [9:0]                         paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire bts_pkg::bts_cand_s [`BTS_NCAND-1:0] trig_cand,
  input wire logic                               bunch_zero_strobe,
  input wire logic [`BTS_OUT_W-1:0]              ser_data,
  input wire logic                               ser_reset,
  input wire logic                               ser_frame,
  input wire logic [`BTS_NCAND-1:0]              cand_ind,
  input wire logic [`BTS_NRANK-1:0]              ranked_output_indicators,
  input wire logic                               test_ind,
  input wire logic                               access_ind
);
  logic       acc;
  logic       wr;
  logic       w46;
  logic       w44;
  logic [7:0] idx;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign idx = paddr[9:2];
  assign w46 = wr && idx == 8'h46;
  assign w44 = wr && idx == 8'h44;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_test_set; wr && idx == 8'h40 |=> test_ind == $past(pwdata[0]); endproperty
  a_test_set: assert property (p_test_set) else $error("test ind missed");
  property p_test_hold; !(wr && (idx == 8'h40 || idx == 8'h4a)) |=> $stable(test_ind); endproperty
  a_test_hold: assert property (p_test_hold) else $error("test ind moved");
  property p_access; acc |-> ##[1:3] access_ind; endproperty
  a_access: assert property (p_access) else $error("access ind missed");
  property p_cand_flag; !test_ind && trig_cand[0].flag |-> ##[1:5] cand_ind[0]; endproperty
  a_cand_flag: assert property (p_cand_flag) else $error("cand ind missed");
  property p_rank1_flag; ser_data[0] |-> ##[1:3] ranked_output_indicators[0]; endproperty
  a_rank1_flag: assert property (p_rank1_flag) else $error("rank1 ind missed");
  property p_rank3_flag; ser_data[80] |-> ##[1:3] ranked_output_indicators[2]; endproperty
  a_rank3_flag: assert property (p_rank3_flag) else $error("rank3 ind missed");
  property p_ser_reset; w46 |=> ser_reset ##1 !ser_reset; endproperty
  a_ser_reset: assert property (p_ser_reset) else $error("ser reset pulse bad");
  property p_ser_cause; ser_reset |-> $past(w46); endproperty
  a_ser_cause: assert property (p_ser_cause) else $error("ser reset uncaused");
  property p_ser_frame; w44 |=> ser_frame ##1 !ser_frame; endproperty
  a_ser_frame: assert property (p_ser_frame) else $error("ser frame pulse bad");
  property p_unmapped; acc && idx >= 8'h64 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
endmodule
bind bts_top bts_top_assertions #(.STRETCH_CYC(STRETCH_CYC)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trig_cand(trig_cand), .bunch_zero_strobe(bunch_zero_strobe), .ser_data(ser_data),
  .ser_reset(ser_reset), .ser_frame(ser_frame), .cand_ind(cand_ind),
  .ranked_output_indicators(ranked_output_indicators), .test_ind(test_ind),
  .access_ind(access_ind)
);
`default_nettype wire

// ===== bts_timing_model.sv
// timing board stand-in: bunch-zero strobe on request
// assumes fire is a one-cycle pulse from the bench on pclk
`timescale 1ns/1ps
`default_nettype none
module bts_timing_model (
  input  wire logic pclk,
  input  wire logic fire,
  output logic      bunch_zero_strobe,
  output logic      first_level_accept
);
  logic [2:0] cnt = 3'h0;
  initial begin
    bunch_zero_strobe = 1'b0;
    first_level_accept = 1'b0;
  end
  // held several cycles so the three-flop synchroniser cannot miss it
  always @(posedge pclk) begin
    if (fire)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    bunch_zero_strobe <= (cnt != 3'h0);
    first_level_accept <= ~first_level_accept;
  end
endmodule
`default_nettype wire

// ===== test_best_three_of_eighteen_sorter.sv
// self-checking bench for the best-three-of-eighteen sorter
// assumes zero-wait apb slave and a short indicator stretch
`timescale 1ns/1ps
`default_nettype none
`include "bts_defines.svh"
module test_best_three_of_eighteen_sorter;
  typedef bts_pkg::bts_cand_s [`BTS_NCAND-1:0] bts_set_t;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         fire = 1'b0;
  logic [9:0]   paddr = 10'h000;
  logic [31:0]  pwdata = 32'h0;
  bts_set_t     trig_cand = '0;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, bunch_zero_strobe, ser_reset, ser_frame, test_ind, access_ind;
  logic         er;
  logic [119:0] ser_data;
  logic [5:0]   cand_ind;
  logic [2:0]   ranked_output_indicators;
  logic [239:0] v;
  logic [143:0] x;
  bts_set_t     s;
  int           errors = 0;
  int           n_checks = 0;
  bts_top #(.STRETCH_CYC(5)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_cand(trig_cand), .bunch_zero_strobe(bunch_zero_strobe), .ser_data(ser_data),
    .ser_reset(ser_reset), .ser_frame(ser_frame), .cand_ind(cand_ind),
    .ranked_output_indicators(ranked_output_indicators), .test_ind(test_ind),
    .access_ind(access_ind)
  );
  bts_timing_model i_tim (
    .pclk(pclk), .fire(fire), .bunch_zero_strobe(bunch_zero_strobe), .first_level_accept()
  );
  always #(`BTS_CLK_PERIOD_NS / 2) pclk = ~pclk;
  // lookup content is entry[9:2] xor memory number
  function automatic logic [7:0] qv(input bts_set_t t, input int c);
    return {t[c].wire_quality_bits, t[c].strip_pattern_bits[7:2]} ^ 8'(c);
  endfunction
  // candidates 0/5, 1/4 and 2/3 always share a quality
  function automatic bts_set_t mk(input int i);
    bts_set_t t;
    logic [9:0] e;
    for (int c = 0; c < 6; c++) begin
      e = {8'(1 + ((i * 3 + c * c) % 5) * 32) ^ 8'(c), 2'(c)};
      t[c] = {20'(i * 16 + c), e[9:8], 9'(i), e[7:0], 1'(i + c)};
    end
    return t;
  endfunction
  function automatic logic [119:0] rk(input bts_set_t t);
    logic [119:0] r;
    logic [5:0] u;
    int b;
    u = '0;
    r = '0;
    for (int k = 0; k < 3; k++) begin
      b = -1;
      for (int c = 0; c < 6; c++)
        if (!u[c] && (b < 0 || qv(t, c) > qv(t, b)))
          b = c;
      u[b] = 1'b1;
      r[40 * k +: 40] = t[b];
    end
    return r;
  endfunction
  task automatic chk(input logic [119:0] g, input logic [119:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic close_out;
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // about three times the expected run length
  initial begin
    #600000;
    errors++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(ser_data, '0);
    chk({cand_ind, ranked_output_indicators, test_ind}, '0);
    @(posedge pclk);
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, 8'h60, 32'(m * 1024));
      for (int e = 0; e < 1024; e++)
        apb(1'b1, 8'h62, 32'(8'(e / 4) ^ 8'(m)));
    end
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      trig_cand <= (i < 15) ? mk(i) : '0;
      #1;
      if (i >= 5) chk(ser_data, rk(mk(i - 5)));
    end
    repeat (12) @(posedge pclk);
    #1;
    chk({cand_ind, ranked_output_indicators}, '0);
    @(posedge pclk);
    s = '0;
    s[3].flag = 1'b1;
    trig_cand <= s;
    @(posedge pclk);
    trig_cand <= '0;
    repeat (2) @(posedge pclk);
    #1;
    chk(cand_ind, 6'h08);
    repeat (4) @(posedge pclk);
    #1;
    chk(ranked_output_indicators, 3'h4);
    @(posedge pclk);
    apb(1'b1, 8'h4a, 32'h0);
    apb(1'b1, 8'h48, 32'h0);
    apb(1'b1, 8'h46, 32'h0);
    apb(1'b1, 8'h44, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk(test_ind, 1'b1);
    apb(1'b1, 8'h50, 32'h200);
    apb(1'b0, 8'h50, 32'h0);
    chk(rd, 32'h200);
    apb(1'b0, 8'h70, 32'h0);
    chk(er, 1'b1);
    // ninth word per lane must be dropped
    for (int w = 0; w < 9; w++) begin
      v = mk(100 + w);
      for (int l = 0; l < 15; l++)
        apb(1'b1, 8'(32 + 2 * l), 32'(v[16 * l +: 16]));
    end
    trig_cand <= mk(3);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (40) @(posedge pclk);
    for (int l = 0; l < 9; l++)
      for (int w = 0; w < 8; w++) begin
        x = {24'h0, rk(mk(100 + w))};
        apb(1'b0, 8'(2 * l), 32'h0);
        chk(rd, x[16 * l +: 16]);
      end
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h4a, 32'h0);
    chk(test_ind, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
